// ### common/osync_pkg.sv
// Constants, types and register map of the output sync parameter block.
// Assumes a 250 MHz clock and an APB slave with an 8-bit byte address.
package osync_pkg;
    // ----------------------------------------
    // Clock and time base
    // ----------------------------------------
    localparam int CLK_MHZ    = 250;
    localparam int NS_PER_CLK = 1000 / CLK_MHZ;
    localparam logic [31:0] NS_STEP = 32'(NS_PER_CLK);
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_ENTRY_COUNT = 8'h00;
    localparam logic [7:0] OFF_MODE_SELECT = 8'h04;
    localparam logic [7:0] OFF_CYCLE       = 8'h08;
    localparam logic [7:0] OFF_SHIFT       = 8'h0c;
    localparam logic [7:0] OFF_MODES_AVAIL = 8'h10;
    localparam logic [7:0] OFF_MIN_PERIOD  = 8'h14;
    localparam logic [7:0] OFF_GAP_MIN     = 8'h18;
    localparam logic [7:0] OFF_MIN_DELAY   = 8'h1c;
    localparam logic [7:0] OFF_MEAS_CTRL   = 8'h20;
    localparam logic [7:0] OFF_MAX_DELAY   = 8'h24;
    localparam logic [7:0] OFF_MISSED      = 8'h2c;
    localparam logic [7:0] OFF_OVERRUN     = 8'h30;
    localparam logic [7:0] OFF_SHORT_GAP   = 8'h34;
    localparam logic [7:0] OFF_IN_SHIFT    = 8'h40;
    localparam logic [7:0] OFF_IN_CALC     = 8'h44;
    localparam logic [7:0] OFF_IN_DELAY    = 8'h48;
    localparam logic [7:0] OFF_LATE_FLAG   = 8'h80;
    localparam logic [7:0] OFF_IRQ_STATUS  = 8'h90;
    localparam logic [7:0] OFF_IRQ_CLEAR   = 8'h94;
    localparam logic [7:0] OFF_IRQ_ENABLE  = 8'h98;
    // ----------------------------------------
    // Reset and fixed values
    // ----------------------------------------
    localparam logic [7:0]  RST_ENTRY_COUNT = 8'h20;
    localparam logic [15:0] RST_MODE_SELECT = 16'h0001;
    localparam logic [15:0] RST_MODES_AVAIL = 16'hc007;
    localparam logic [31:0] RST_MIN_DELAY   = 32'h00000000;
    localparam logic [15:0] RST_MEAS_CTRL   = 16'h0000;
    localparam logic [15:0] MEAS_START      = 16'h0001;
    localparam logic [15:0] MODE_LIMIT      = 16'h0004;
    // ----------------------------------------
    // Interrupt bit positions
    // ----------------------------------------
    localparam int IRQ_W       = 4;
    localparam int IRQ_MISSED  = 0;
    localparam int IRQ_OVERRUN = 1;
    localparam int IRQ_SHORT   = 2;
    localparam int IRQ_LATE    = 3;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        MODE_LOCAL_TIMER = 2'b00,
        MODE_BUFFER_EVT  = 2'b01,
        MODE_FIRST_PULSE = 2'b10,
        MODE_SECOND_PULSE = 2'b11
    } sync_mode_e;
    typedef struct packed {
        logic run_state;
        logic output_buffer_manager;
        logic first_clock_pulse;
        logic second_clock_pulse;
        logic outputs_driven;
        logic inputs_latched;
        logic inputs_ready;
    } sync_evt_s;
    localparam int EVT_W = $bits(sync_evt_s);
endpackage

// ### hw/output_sync_parameters.sv
// Output synchronization parameter object with timing measurement and error counters.
// Assumes an APB master on clk and asynchronous event pins that need synchronising.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
module output_sync_parameters
    import osync_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Asynchronous event pins
    input  wire sync_evt_s   evt_pin,
    // Block outputs
    output logic             local_cycle_tick,
    output logic             irq
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [EVT_W-1:0] meta_ff;
    logic [EVT_W-1:0] sync_ff;
    logic [EVT_W-1:0] prev_ff;
    sync_evt_s        lvl;
    sync_evt_s        rise;

    generate
        for (genvar i = 0; i < EVT_W; i++) begin : g_sync
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    meta_ff[i] <= 1'b0;
                    sync_ff[i] <= 1'b0;
                    prev_ff[i] <= 1'b0;
                end else begin
                    meta_ff[i] <= evt_pin[i];
                    sync_ff[i] <= meta_ff[i];
                    prev_ff[i] <= sync_ff[i];
                end
            end
        end
    endgenerate

    assign lvl  = sync_ff;
    assign rise = sync_ff & ~prev_ff;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] max32(input logic [31:0] a, input logic [31:0] b);
        max32 = (b > a) ? b : a;
    endfunction

    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    // ----------------------------------------
    // Register write path
    // ----------------------------------------
    logic              wr_en;
    logic [15:0]       mode_ff;
    logic [31:0]       cycle_ff;
    logic [15:0]       ctrl_ff;
    logic [IRQ_W-1:0]  irq_en_ff;
    logic [IRQ_W-1:0]  irq_stat_ff;
    logic [IRQ_W-1:0]  irq_evt;
    logic              meas_restart;
    sync_mode_e        mode;
    logic              dc_mode;
    logic              measuring;

    assign pready = 1'b1;
    assign wr_en  = psel & penable & pwrite;

    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = wr_en && (paddr == off);
    endfunction

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_ff <= RST_MODE_SELECT;
        end else if (wr_hit(OFF_MODE_SELECT) && pwdata[15:0] < MODE_LIMIT) begin
            // Unsupported mode values are dropped so the running mode stays valid
            mode_ff <= pwdata[15:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cycle_ff <= 32'h00000000;
        end else if (wr_hit(OFF_CYCLE)) begin
            cycle_ff <= pwdata;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_ff <= RST_MEAS_CTRL;
        end else if (wr_hit(OFF_MEAS_CTRL)) begin
            ctrl_ff <= pwdata[15:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_en_ff <= '0;
        end else if (wr_hit(OFF_IRQ_ENABLE)) begin
            irq_en_ff <= pwdata[IRQ_W-1:0];
        end
    end

    // A new event wins over a clear in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_stat_ff <= '0;
        end else if (wr_hit(OFF_IRQ_CLEAR)) begin
            irq_stat_ff <= (irq_stat_ff & ~pwdata[IRQ_W-1:0]) | irq_evt;
        end else begin
            irq_stat_ff <= irq_stat_ff | irq_evt;
        end
    end

    assign irq          = |(irq_stat_ff & irq_en_ff);
    assign mode         = sync_mode_e'(mode_ff[1:0]);
    assign dc_mode      = mode_ff[1];
    assign measuring    = (ctrl_ff == MEAS_START);
    assign meas_restart = wr_hit(OFF_MEAS_CTRL) && (pwdata[15:0] == MEAS_START);

    // ----------------------------------------
    // Time base and local timer
    // ----------------------------------------
    logic [31:0] now_ff;
    logic [31:0] acc_ff;
    logic        tick_ff;
    logic [32:0] acc_next;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            now_ff <= 32'h00000000;
        end else begin
            now_ff <= now_ff + NS_STEP;
        end
    end

    assign acc_next = {1'b0, acc_ff} + {1'b0, NS_STEP};

    // Period zero leaves the timer idle rather than ticking every cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_ff  <= 32'h00000000;
            tick_ff <= 1'b0;
        end else if (mode != MODE_LOCAL_TIMER || cycle_ff == 32'h00000000) begin
            acc_ff  <= 32'h00000000;
            tick_ff <= 1'b0;
        end else if (acc_next >= {1'b0, cycle_ff}) begin
            acc_ff  <= 32'h00000000;
            tick_ff <= 1'b1;
        end else begin
            acc_ff  <= acc_next[31:0];
            tick_ff <= 1'b0;
        end
    end

    assign local_cycle_tick = tick_ff;

    // ----------------------------------------
    // Cycle tracking and timestamps
    // ----------------------------------------
    logic        cycle_start;
    logic        pend_ff;
    logic        seen_ff;
    logic        armed_ff;
    logic [31:0] t0_ff;
    logic [31:0] t1_ff;
    logic [31:0] tstart_ff;
    logic [31:0] tbuf_ff;
    logic [31:0] tlatch_ff;

    always_comb begin
        case (mode)
            MODE_LOCAL_TIMER: cycle_start = tick_ff;
            MODE_BUFFER_EVT:  cycle_start = rise.output_buffer_manager;
            default:          cycle_start = rise.first_clock_pulse;
        endcase
    end

    // Outputs still owed for the current cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_ff <= 1'b0;
        end else if (cycle_start) begin
            pend_ff <= 1'b1;
        end else if (rise.outputs_driven) begin
            pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            seen_ff  <= 1'b0;
            armed_ff <= 1'b0;
        end else if (rise.first_clock_pulse) begin
            seen_ff  <= 1'b0;
            armed_ff <= 1'b1;
        end else if (rise.output_buffer_manager) begin
            seen_ff  <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            t0_ff     <= 32'h00000000;
            t1_ff     <= 32'h00000000;
            tstart_ff <= 32'h00000000;
            tbuf_ff   <= 32'h00000000;
            tlatch_ff <= 32'h00000000;
        end else begin
            if (rise.first_clock_pulse)     t0_ff     <= now_ff;
            if (rise.second_clock_pulse)    t1_ff     <= now_ff;
            if (cycle_start)                tstart_ff <= now_ff;
            if (rise.output_buffer_manager) tbuf_ff   <= now_ff;
            if (rise.inputs_latched)        tlatch_ff <= now_ff;
        end
    end

    // ----------------------------------------
    // Measured maxima
    // ----------------------------------------
    logic [31:0] shift_ff;
    logic [31:0] min_period_ff;
    logic [31:0] gap_min_ff;
    logic [31:0] max_delay_ff;
    logic [31:0] in_shift_ff;
    logic [31:0] in_calc_ff;
    logic [31:0] in_delay_ff;

    // Maxima only move forward while measuring; a restart wipes them first
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_ff      <= 32'h00000000;
            min_period_ff <= 32'h00000000;
            gap_min_ff    <= 32'h00000000;
            max_delay_ff  <= 32'h00000000;
        end else if (meas_restart) begin
            shift_ff      <= 32'h00000000;
            min_period_ff <= 32'h00000000;
            gap_min_ff    <= 32'h00000000;
            max_delay_ff  <= 32'h00000000;
        end else if (measuring && rise.outputs_driven) begin
            min_period_ff <= max32(min_period_ff, now_ff - tstart_ff);
            if (dc_mode) begin
                shift_ff     <= max32(shift_ff, now_ff - t0_ff);
                max_delay_ff <= max32(max_delay_ff, now_ff - t1_ff);
                gap_min_ff   <= max32(gap_min_ff, now_ff - tbuf_ff);
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_shift_ff <= 32'h00000000;
            in_calc_ff  <= 32'h00000000;
            in_delay_ff <= 32'h00000000;
        end else if (meas_restart) begin
            in_shift_ff <= 32'h00000000;
            in_calc_ff  <= 32'h00000000;
            in_delay_ff <= 32'h00000000;
        end else if (measuring && dc_mode) begin
            if (rise.inputs_latched) begin
                in_shift_ff <= max32(in_shift_ff, now_ff - t0_ff);
                in_delay_ff <= max32(in_delay_ff, now_ff - t1_ff);
            end
            if (rise.inputs_ready) begin
                in_calc_ff  <= max32(in_calc_ff, now_ff - tlatch_ff);
            end
        end
    end

    // ----------------------------------------
    // Error counters and late flag
    // ----------------------------------------
    logic [15:0] missed_ff;
    logic [15:0] overrun_ff;
    logic [15:0] short_ff;
    logic        late_ff;
    logic        miss_evt;
    logic        over_evt;
    logic        short_evt;
    logic        late_evt;

    // A buffer event coinciding with the pulse still counts as seen
    assign miss_evt  = lvl.run_state && dc_mode && rise.first_clock_pulse && armed_ff
                       && !seen_ff && !rise.output_buffer_manager;
    assign over_evt  = lvl.run_state && cycle_start && pend_ff;
    assign short_evt = dc_mode && rise.second_clock_pulse && ((now_ff - t0_ff) < gap_min_ff);
    assign late_evt  = dc_mode && rise.first_clock_pulse && pend_ff;

    always_comb begin
        irq_evt              = '0;
        irq_evt[IRQ_MISSED]  = miss_evt;
        irq_evt[IRQ_OVERRUN] = over_evt;
        irq_evt[IRQ_SHORT]   = short_evt;
        irq_evt[IRQ_LATE]    = late_evt;
    end

    // Counters saturate so a wrap cannot hide a long error burst
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            missed_ff <= 16'h0000;
        end else if (miss_evt) begin
            missed_ff <= sat_inc(missed_ff);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            overrun_ff <= 16'h0000;
        end else if (over_evt) begin
            overrun_ff <= sat_inc(overrun_ff);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            short_ff <= 16'h0000;
        end else if (short_evt) begin
            short_ff <= sat_inc(short_ff);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            late_ff <= 1'b0;
        end else if (!dc_mode) begin
            late_ff <= 1'b0;
        end else if (rise.first_clock_pulse) begin
            late_ff <= pend_ff;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [31:0] nxt_prdata;
    logic        nxt_err;
    logic [31:0] prdata_ff;
    logic        err_ff;

    // Read-only entries are decoded as mapped, so writes to them answer without error
    always_comb begin
        nxt_prdata = 32'h00000000;
        nxt_err    = 1'b0;
        case (paddr)
            OFF_ENTRY_COUNT: nxt_prdata = {24'h000000, RST_ENTRY_COUNT};
            OFF_MODE_SELECT: nxt_prdata = {16'h0000, mode_ff};
            OFF_CYCLE:       nxt_prdata = cycle_ff;
            OFF_SHIFT:       nxt_prdata = shift_ff;
            OFF_MODES_AVAIL: nxt_prdata = {16'h0000, RST_MODES_AVAIL};
            OFF_MIN_PERIOD:  nxt_prdata = min_period_ff;
            OFF_GAP_MIN:     nxt_prdata = gap_min_ff;
            OFF_MIN_DELAY:   nxt_prdata = RST_MIN_DELAY;
            OFF_MEAS_CTRL:   nxt_prdata = {16'h0000, ctrl_ff};
            OFF_MAX_DELAY:   nxt_prdata = max_delay_ff;
            OFF_MISSED:      nxt_prdata = {16'h0000, missed_ff};
            OFF_OVERRUN:     nxt_prdata = {16'h0000, overrun_ff};
            OFF_SHORT_GAP:   nxt_prdata = {16'h0000, short_ff};
            OFF_IN_SHIFT:    nxt_prdata = in_shift_ff;
            OFF_IN_CALC:     nxt_prdata = in_calc_ff;
            OFF_IN_DELAY:    nxt_prdata = in_delay_ff;
            OFF_LATE_FLAG:   nxt_prdata = {31'h00000000, late_ff};
            OFF_IRQ_STATUS:  nxt_prdata = {{(32-IRQ_W){1'b0}}, irq_stat_ff};
            OFF_IRQ_CLEAR:   nxt_prdata = 32'h00000000;
            OFF_IRQ_ENABLE:  nxt_prdata = {{(32-IRQ_W){1'b0}}, irq_en_ff};
            default:         nxt_err    = 1'b1;
        endcase
    end

    // Captured in the setup cycle so data and error come from flops in the access cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_ff <= 32'h00000000;
            err_ff    <= 1'b0;
        end else if (psel && !penable) begin
            prdata_ff <= pwrite ? 32'h00000000 : nxt_prdata;
            err_ff    <= nxt_err;
        end
    end

    assign prdata  = prdata_ff;
    assign pslverr = err_ff & psel & penable;
endmodule

// ### bench/output_sync_parameters_properties.sv
// Port checker for the output sync parameter block, bound to its top module.
// Assumes one clock domain, zero-wait APB and event pins seen three clocks late.
`timescale 1ns/1ns
module output_sync_parameters_properties
    import osync_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Events and outputs
    input wire sync_evt_s   evt_pin,
    input wire logic        local_cycle_tick,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ----
    // Quiet time since the last bus access or pin change
    // ----
    logic [3:0] quiet_ff;
    sync_evt_s  evt_prev_ff;
    logic       rd_acc;
    assign rd_acc = psel && penable && !pwrite;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            quiet_ff    <= 4'h0;
            evt_prev_ff <= '0;
        end else begin
            evt_prev_ff <= evt_pin;
            if (psel || evt_pin != evt_prev_ff) begin
                quiet_ff <= 4'h0;
            end else if (quiet_ff != 4'hf) begin
                quiet_ff <= quiet_ff + 4'h1;
            end
        end
    end
    // ----
    // Assertions
    // ----
    chk_ready_always:
        assert property (pready) else $error("pready dropped");
    chk_err_in_access:
        assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
    chk_write_read_zero:
        assert property (psel && penable && pwrite |-> prdata == 32'h0) else $error("prdata not 0 on write");
    chk_header_fixed:
        assert property (rd_acc && paddr == OFF_ENTRY_COUNT |-> prdata == 32'h20) else $error("header wrong");
    chk_modes_word:
        assert property (rd_acc && paddr == OFF_MODES_AVAIL |-> prdata == 32'hc007) else $error("modes wrong");
    chk_mode_range:
        assert property (rd_acc && paddr == OFF_MODE_SELECT |-> prdata < 32'h4) else $error("mode out of range");
    chk_flag_one_bit:
        assert property (rd_acc && paddr == OFF_LATE_FLAG |-> prdata[31:1] == 31'h0) else $error("flag too wide");
    chk_irq_rise_cause:
        assert property ($rose(irq) |-> quiet_ff < 4'h7) else $error("irq rose without cause");
    chk_irq_fall_write:
        assert property ($fell(irq) |-> $past(penable) && $past(pwrite)) else $error("irq fell without write");
    cover property ($rose(irq));
    cover property (pslverr);
    cover property (local_cycle_tick);
    cover property (rd_acc && paddr == OFF_LATE_FLAG && prdata[0]);
endmodule
bind output_sync_parameters output_sync_parameters_properties chk_i (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt_pin(evt_pin), .local_cycle_tick(local_cycle_tick), .irq(irq));

// ### bench/event_source.sv
// Behavioural far side that raises the sync event pins.
// Assumes the bench clock; every pin changes by non-blocking assignment after a rising edge.
`timescale 1ns/1ns
module event_source
    import osync_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Event pins
    output sync_evt_s evt
);
    initial evt = '0;
    // Two clocks high so the two-flop synchroniser never drops a pulse
    task automatic pulse(input int b, input int gap);
        @(posedge clk);
        evt[b] <= 1'b1;
        repeat (2) @(posedge clk);
        evt[b] <= 1'b0;
        repeat (gap) @(posedge clk);
    endtask
    task automatic set_run(input logic v);
        @(posedge clk);
        evt.run_state <= v;
    endtask
endmodule

// ### bench/output_sync_parameters_tb.sv
// Self-checking bench for the output sync parameter block.
// Assumes zero-wait APB answers and event pins driven by event_source.
`timescale 1ns/1ns
module output_sync_parameters_tb
    import osync_pkg::*;
;
    logic        clk     = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        last_err;
    sync_evt_s   evt_pin;
    logic        local_cycle_tick;
    logic        irq;
    int          num_errors = 0;
    int          checked    = 0;
    always #2 clk = ~clk;
    output_sync_parameters dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt_pin(evt_pin), .local_cycle_tick(local_cycle_tick), .irq(irq));
    event_source src (.clk(clk), .evt(evt_pin));
    // ----
    // Tasks
    // ----
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 64) begin
            num_errors++;
            wrap_up();
        end
        r        = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk($sformatf("reg %h", a), r, exp);
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        int ticks;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rd(OFF_ENTRY_COUNT, 32'h20);
        rd(OFF_MODE_SELECT, 32'h1);
        rd(OFF_MODES_AVAIL, 32'hc007);
        rd(OFF_MEAS_CTRL, 32'h0);
        rd(OFF_MISSED, 32'h0);
        rd(OFF_OVERRUN, 32'h0);
        rd(OFF_SHORT_GAP, 32'h0);
        rd(OFF_LATE_FLAG, 32'h0);
        wr(OFF_MODES_AVAIL, 32'h1234);
        rd(OFF_MODES_AVAIL, 32'hc007);
        wr(OFF_ENTRY_COUNT, 32'h7);
        rd(OFF_ENTRY_COUNT, 32'h20);
        rd(8'h28, 32'h0);
        chk("pslverr", {31'h0, last_err}, 32'h1);
        for (int m = 0; m < 5; m++) begin
            wr(OFF_MODE_SELECT, 32'(m));
            rd(OFF_MODE_SELECT, (m < 4) ? 32'(m) : 32'h3);
        end
        // Local timer: 20 ns period at 4 ns per clock gives one tick in five
        wr(OFF_CYCLE, 32'd20);
        rd(OFF_CYCLE, 32'd20);
        wr(OFF_MODE_SELECT, 32'h0);
        repeat (10) @(posedge clk);
        ticks = 0;
        repeat (50) begin
            @(posedge clk);
            ticks += int'(local_cycle_tick);
        end
        chk("ticks", 32'(ticks), 32'd10);
        // Pulse-driven cycle; outputs_driven first so no cycle is left pending
        wr(OFF_MODE_SELECT, 32'h2);
        src.pulse(2, 4);
        src.set_run(1'b1);
        wr(OFF_MEAS_CTRL, 32'h1);
        src.pulse(4, 0);
        src.pulse(5, 7);
        src.pulse(2, 0);
        src.pulse(4, 0);
        src.pulse(3, 0);
        src.pulse(4, 4);
        rd(OFF_SHIFT, 32'd52);
        rd(OFF_MIN_PERIOD, 32'd52);
        rd(OFF_GAP_MIN, 32'd40);
        rd(OFF_MISSED, 32'h1);
        rd(OFF_OVERRUN, 32'h1);
        rd(OFF_SHORT_GAP, 32'h1);
        rd(OFF_LATE_FLAG, 32'h1);
        rd(OFF_IRQ_STATUS, 32'hf);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(OFF_IRQ_ENABLE, 32'h2);
        #1;
        chk("irq", {31'h0, irq}, 32'h1);
        wr(OFF_IRQ_CLEAR, 32'h2);
        #1;
        chk("irq", {31'h0, irq}, 32'h0);
        rd(OFF_IRQ_STATUS, 32'hd);
        wr(OFF_MEAS_CTRL, 32'h1);
        rd(OFF_SHIFT, 32'h0);
        // Pulse, driven, latched, ready three clocks apart: 12, 24 and 12 ns
        src.pulse(3, 0);
        src.pulse(2, 0);
        src.pulse(1, 0);
        src.pulse(0, 4);
        rd(OFF_MAX_DELAY, 32'd12);
        rd(OFF_IN_DELAY, 32'd24);
        rd(OFF_IN_CALC, 32'd12);
        wr(OFF_MEAS_CTRL, 32'h0);
        rd(OFF_MEAS_CTRL, 32'h0);
        // Stopped: a 28 ns pulse-to-output delay must not reach the maximum
        src.pulse(3, 4);
        src.pulse(2, 4);
        rd(OFF_MAX_DELAY, 32'd12);
        wr(OFF_MODE_SELECT, 32'h1);
        rd(OFF_LATE_FLAG, 32'h0);
        // Buffer event mode: a second event before outputs are driven overruns
        src.pulse(5, 1);
        src.pulse(5, 4);
        rd(OFF_OVERRUN, 32'h2);
        chk("irq", {31'h0, irq}, 32'h1);
        wrap_up();
    end
endmodule
